// [hdl/fgd_pkg.sv]
package fgd_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_RX_ERR     = 16'h8008;
    localparam logic [15:0] IDX_ODD_PRE    = 16'h8011;
    localparam logic [15:0] IDX_FALSE_CAR  = 16'h8013;
    localparam logic [15:0] IDX_GEN_EN     = 16'h8020;
    localparam logic [15:0] IDX_GEN_CTRL   = 16'h8021;
    localparam logic [15:0] IDX_GEN_CONT   = 16'h8022;
    localparam logic [15:0] IDX_GEN_IRQ_EN = 16'h8023;
    localparam logic [15:0] IDX_GEN_LEN    = 16'h8025;
    localparam logic [15:0] IDX_GEN_IFG    = 16'h8026;
    localparam logic [15:0] IDX_NFRM_H     = 16'h8027;
    localparam logic [15:0] IDX_NFRM_L     = 16'h8028;
    localparam logic [15:0] IDX_GEN_DONE   = 16'h8029;
    localparam logic [15:0] IDX_IRQ_STAT   = 16'h8030;
    localparam logic [15:0] IDX_IRQ_MASK   = 16'h8031;
    localparam logic [15:0] IDX_DIAG_CLK   = 16'h8032;

    // Field positions.
    localparam int          ENABLE_BIT   = 0;
    localparam int          RESTART_BIT  = 3;
    localparam int          PATTERN_LSB  = 0;
    localparam int          DONE_BIT     = 0;
    localparam int          IRQ_GEN_BIT  = 0;

    // Reset values.
    localparam logic [2:0]  PATTERN_RST  = 3'h1;
    localparam logic [15:0] LEN_RST      = 16'h006b;
    localparam logic [15:0] IFG_RST      = 16'h000c;
    localparam logic [15:0] NFRM_H_RST   = 16'h0000;
    localparam logic [15:0] NFRM_L_RST   = 16'h0100;
    localparam logic [15:0] LFSR_SEED    = 16'hace1;

    // Data field patterns.
    localparam logic [2:0]  PAT_STOP     = 3'h0;
    localparam logic [2:0]  PAT_RANDOM   = 3'h1;
    localparam logic [2:0]  PAT_ZEROS    = 3'h2;
    localparam logic [2:0]  PAT_ONES     = 3'h3;
    localparam logic [2:0]  PAT_ALT55    = 3'h4;
    localparam logic [2:0]  PAT_DOWN     = 3'h5;

    // Frame layout in bytes: two addresses and a length field, then FCS.
    localparam logic [15:0] HDR_BYTES    = 16'd14;
    localparam logic [15:0] FCS_BYTES    = 16'd4;
    localparam logic [7:0]  DST_BYTE     = 8'hff;
    localparam logic [47:0] SRC_MAC      = 48'h02_00_00_00_00_01;
    localparam logic [31:0] CRC_POLY     = 32'hedb88320;
    localparam logic [31:0] CRC_INIT     = 32'hffffffff;

    // One byte on a 10 Mb/s link lasts 800 ns.
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          BYTE_TIME_NS  = 800;
    localparam int          BYTE_CYCLES   = BYTE_TIME_NS / CLK_PERIOD_NS;
    localparam int          DIV_W         = 6;

    typedef enum logic [2:0] {
        FG_IDLE,
        FG_HDR,
        FG_DATA,
        FG_FCS,
        FG_GAP
    } fgd_state_e;

endpackage

// [hdl/fgd_crc32.sv]
module fgd_crc32
    import fgd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        init_i,
    input  wire logic        en_i,
    input  wire logic [7:0]  data_i,
    output logic      [31:0] crc_o
);

    logic [31:0] crc_q;
    logic [31:0] crc_d;

    // Reflected CRC-32, least significant bit of each byte first.
    always_comb begin
        crc_d = crc_q;
        for (int i = 0; i < 8; i++) begin
            if (crc_d[0] ^ data_i[i]) begin
                crc_d = (crc_d >> 1) ^ CRC_POLY;
            end else begin
                crc_d = crc_d >> 1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || init_i) begin
            crc_q <= CRC_INIT;
        end else if (en_i) begin
            crc_q <= crc_d;
        end
    end

    assign crc_o = crc_q;

endmodule

// [hdl/fgd_frame_gen_diag.sv]
// What this block does
// - Snapshot of odd-preamble packet count, sixteen bits.
// - Snapshot of bad-delimiter false carrier count.
// - Error counter read captures both snapshots together.
// - Generator enabled: PHY data from generator only.
// - Restart bit restarts generator, then self-clears.
// - Pattern codes: random, zeros, ones data.
// - Pattern zero: finish frame, then stop.
// - Codes for 0x55 bytes and countdown bytes.
// - Continuous mode emits frames until disabled.
// - Burst mode emits programmed count, then stops.
// - Interrupt enable raises interrupt after burst completes.
// - Interrupt needs unmask; latched status bit shown.
// - Data length programmable; frame adds eighteen bytes.
// - Frame carries addresses, length field and FCS.
// - Receive error counter clears when read.
// - Burst count split high/low, loaded at start.
// - Done flag latches until software reads it.
// - Programmable interframe gap in bytes, default twelve.
module fgd_frame_gen_diag
    import fgd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [17:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        rx_error_i,
    input  wire logic        odd_preamble_i,
    input  wire logic        bad_ssd_i,
    input  wire logic [7:0]  mac_txd_i,
    input  wire logic        mac_tx_en_i,
    input  wire logic        mac_tx_stb_i,
    output logic      [7:0]  phy_txd_o,
    output logic             phy_tx_en_o,
    output logic             phy_tx_stb_o,
    output logic             irq_o
);

    logic             ack_q;
    logic [31:0]      dat_q;
    logic [15:0]      rd_val;
    logic [15:0]      err_q;
    logic [15:0]      odd_live_q;
    logic [15:0]      fc_live_q;
    logic [15:0]      odd_snap_q;
    logic [15:0]      fc_snap_q;
    logic             gen_en_q;
    logic             diag_clk_q;
    logic [2:0]       pattern_q;
    logic             cont_q;
    logic             irq_en_q;
    logic [15:0]      len_q;
    logic [15:0]      ifg_q;
    logic [15:0]      nfrm_h_q;
    logic [15:0]      nfrm_l_q;
    logic             done_q;
    logic             stat_q;
    logic             mask_q;
    logic [DIV_W-1:0] div_q;
    logic             run_q;
    fgd_state_e       state_q;
    fgd_state_e       state_d;
    logic [15:0]      bcnt_q;
    logic [15:0]      bcnt_d;
    logic [31:0]      frames_q;
    logic [31:0]      frames_d;
    logic [15:0]      lfsr_q;
    logic             done_set;
    logic             crc_init;
    logic [31:0]      crc_val;
    logic [7:0]       gen_byte;
    logic [7:0]       phy_txd_q;
    logic             phy_en_q;
    logic             phy_stb_q;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] lfsr_step8(input logic [15:0] s);
        logic [15:0] v;
        v = s;
        for (int i = 0; i < 8; i++) begin
            v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        end
        lfsr_step8 = v;
    endfunction

    // Bus decode. Writes land on the edge that sees ack high; reads and
    // their side effects happen on the first edge of the request, so the
    // returned word and the clear-on-read can never disagree.
    wire logic [15:0] idx      = adr_i[17:2];
    wire logic        req      = cyc_i & stb_i;
    wire logic        req_new  = req & ~ack_q;
    wire logic        wr_fire  = req & we_i & ack_q;
    wire logic        rd_new   = req_new & ~we_i;
    wire logic        lo_we    = wr_fire & sel_i[0];
    wire logic        wr_en    = lo_we & (idx == IDX_GEN_EN);
    wire logic        wr_ctrl  = lo_we & (idx == IDX_GEN_CTRL);
    wire logic        wr_cont  = lo_we & (idx == IDX_GEN_CONT);
    wire logic        wr_irqen = lo_we & (idx == IDX_GEN_IRQ_EN);
    wire logic        wr_stat  = lo_we & (idx == IDX_IRQ_STAT);
    wire logic        wr_mask  = lo_we & (idx == IDX_IRQ_MASK);
    wire logic        wr_diag  = lo_we & (idx == IDX_DIAG_CLK);
    wire logic        wr_len   = wr_fire & (idx == IDX_GEN_LEN);
    wire logic        wr_ifg   = wr_fire & (idx == IDX_GEN_IFG);
    wire logic        wr_nh    = wr_fire & (idx == IDX_NFRM_H);
    wire logic        wr_nl    = wr_fire & (idx == IDX_NFRM_L);
    wire logic        rd_err   = rd_new & (idx == IDX_RX_ERR);
    wire logic        rd_done  = rd_new & (idx == IDX_GEN_DONE);
    wire logic        restart  = wr_ctrl & dat_i[RESTART_BIT];
    wire logic        run      = gen_en_q & diag_clk_q;
    wire logic        start    = run & (~run_q | restart);
    wire logic        tick     = div_q == DIV_W'(BYTE_CYCLES - 1);
    wire logic        gen_tx   = (state_q == FG_HDR) | (state_q == FG_DATA)
                                 | (state_q == FG_FCS);
    wire logic        crc_en   = run & ~start & tick
                                 & ((state_q == FG_HDR) | (state_q == FG_DATA));
    wire logic [47:0] sa_sh    = SRC_MAC << {bcnt_q[3:0] - 4'd6, 3'b000};
    wire logic [31:0] fcs_sh   = crc_val >> {bcnt_q[1:0], 3'b000};

    always_comb begin
        unique case (idx)
            IDX_RX_ERR:     rd_val = err_q;
            IDX_ODD_PRE:    rd_val = odd_snap_q;
            IDX_FALSE_CAR:  rd_val = fc_snap_q;
            IDX_GEN_EN:     rd_val = {15'h0, gen_en_q};
            IDX_GEN_CTRL:   rd_val = {13'h0, pattern_q};
            IDX_GEN_CONT:   rd_val = {15'h0, cont_q};
            IDX_GEN_IRQ_EN: rd_val = {15'h0, irq_en_q};
            IDX_GEN_LEN:    rd_val = len_q;
            IDX_GEN_IFG:    rd_val = ifg_q;
            IDX_NFRM_H:     rd_val = nfrm_h_q;
            IDX_NFRM_L:     rd_val = nfrm_l_q;
            IDX_GEN_DONE:   rd_val = {15'h0, done_q};
            IDX_IRQ_STAT:   rd_val = {15'h0, stat_q};
            IDX_IRQ_MASK:   rd_val = {15'h0, mask_q};
            IDX_DIAG_CLK:   rd_val = {15'h0, diag_clk_q};
            default:        rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req_new;
            if (rd_new) begin
                dat_q <= {16'h0000, rd_val};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_q <= 16'h0000;
        end else if (rd_err) begin
            err_q <= {15'h0, rx_error_i};
        end else if (rx_error_i) begin
            err_q <= err_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odd_live_q <= 16'h0000;
            fc_live_q  <= 16'h0000;
            odd_snap_q <= 16'h0000;
            fc_snap_q  <= 16'h0000;
        end else begin
            odd_live_q <= odd_live_q + {15'h0, odd_preamble_i};
            fc_live_q  <= fc_live_q + {15'h0, bad_ssd_i};
            if (rd_err) begin
                odd_snap_q <= odd_live_q;
                fc_snap_q  <= fc_live_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_en_q   <= 1'b0;
            diag_clk_q <= 1'b0;
            pattern_q  <= PATTERN_RST;
            cont_q     <= 1'b0;
            irq_en_q   <= 1'b0;
            mask_q     <= 1'b0;
        end else begin
            if (wr_en)    gen_en_q   <= dat_i[ENABLE_BIT];
            if (wr_diag)  diag_clk_q <= dat_i[ENABLE_BIT];
            if (wr_ctrl)  pattern_q  <= dat_i[PATTERN_LSB +: 3];
            if (wr_cont)  cont_q     <= dat_i[ENABLE_BIT];
            if (wr_irqen) irq_en_q   <= dat_i[ENABLE_BIT];
            if (wr_mask)  mask_q     <= dat_i[IRQ_GEN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_q    <= LEN_RST;
            ifg_q    <= IFG_RST;
            nfrm_h_q <= NFRM_H_RST;
            nfrm_l_q <= NFRM_L_RST;
        end else begin
            if (wr_len) len_q    <= merge16(len_q, dat_i, sel_i);
            if (wr_ifg) ifg_q    <= merge16(ifg_q, dat_i, sel_i);
            if (wr_nh)  nfrm_h_q <= merge16(nfrm_h_q, dat_i, sel_i);
            if (wr_nl)  nfrm_l_q <= merge16(nfrm_l_q, dat_i, sel_i);
        end
    end

    // A completion in the same cycle as the clearing access wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            stat_q <= 1'b0;
        end else begin
            done_q <= done_set | (done_q & ~rd_done);
            stat_q <= (done_set & irq_en_q)
                      | (stat_q & ~(wr_stat & dat_i[IRQ_GEN_BIT]));
        end
    end

    assign irq_o = stat_q & mask_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || start) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_comb begin
        state_d  = state_q;
        bcnt_d   = bcnt_q;
        frames_d = frames_q;
        done_set = 1'b0;
        crc_init = 1'b0;
        if (!run) begin
            state_d = FG_IDLE;
        end else if (start) begin
            frames_d = {nfrm_h_q, nfrm_l_q};
            bcnt_d   = 16'h0000;
            if (pattern_q == PAT_STOP) begin
                state_d = FG_IDLE;
            end else if (!cont_q && {nfrm_h_q, nfrm_l_q} == 32'h0) begin
                state_d  = FG_IDLE;
                done_set = 1'b1;
            end else begin
                state_d  = FG_HDR;
                crc_init = 1'b1;
            end
        end else if (tick) begin
            unique case (state_q)
                FG_IDLE: begin
                    state_d = FG_IDLE;
                end
                FG_HDR: begin
                    if (bcnt_q == HDR_BYTES - 16'h1) begin
                        bcnt_d  = 16'h0000;
                        state_d = (len_q == 16'h0) ? FG_FCS : FG_DATA;
                    end else begin
                        bcnt_d = bcnt_q + 16'h1;
                    end
                end
                FG_DATA: begin
                    if (bcnt_q == len_q - 16'h1) begin
                        bcnt_d  = 16'h0000;
                        state_d = FG_FCS;
                    end else begin
                        bcnt_d = bcnt_q + 16'h1;
                    end
                end
                FG_FCS: begin
                    if (bcnt_q == FCS_BYTES - 16'h1) begin
                        bcnt_d = 16'h0000;
                        if (!cont_q) begin
                            frames_d = frames_q - 32'h1;
                        end
                        if (pattern_q == PAT_STOP) begin
                            state_d = FG_IDLE;
                        end else if (!cont_q && frames_q == 32'h1) begin
                            state_d  = FG_IDLE;
                            done_set = 1'b1;
                        end else if (ifg_q == 16'h0) begin
                            state_d  = FG_HDR;
                            crc_init = 1'b1;
                        end else begin
                            state_d = FG_GAP;
                        end
                    end else begin
                        bcnt_d = bcnt_q + 16'h1;
                    end
                end
                FG_GAP: begin
                    if (bcnt_q == ifg_q - 16'h1) begin
                        bcnt_d   = 16'h0000;
                        state_d  = (pattern_q == PAT_STOP) ? FG_IDLE : FG_HDR;
                        crc_init = pattern_q != PAT_STOP;
                    end else begin
                        bcnt_d = bcnt_q + 16'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q    <= 1'b0;
            state_q  <= FG_IDLE;
            bcnt_q   <= 16'h0000;
            frames_q <= 32'h0000_0000;
        end else begin
            run_q    <= run;
            state_q  <= state_d;
            bcnt_q   <= bcnt_d;
            frames_q <= frames_d;
        end
    end

    // The generator keeps its sequence state between frames, stepping only on data bytes, so random
    // data does not repeat from one frame to the next.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_q <= LFSR_SEED;
        end else if (run && tick && state_q == FG_DATA) begin
            lfsr_q <= lfsr_step8(lfsr_q);
        end
    end

    fgd_crc32 u_crc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .init_i (crc_init),
        .en_i   (crc_en),
        .data_i (gen_byte),
        .crc_o  (crc_val)
    );

    always_comb begin
        gen_byte = 8'h00;
        unique case (state_q)
            FG_HDR: begin
                if (bcnt_q < 16'd6) begin
                    gen_byte = DST_BYTE;
                end else if (bcnt_q < 16'd12) begin
                    gen_byte = sa_sh[47:40];
                end else if (bcnt_q == 16'd12) begin
                    gen_byte = len_q[15:8];
                end else begin
                    gen_byte = len_q[7:0];
                end
            end
            FG_DATA: begin
                unique case (pattern_q)
                    PAT_RANDOM: gen_byte = lfsr_q[7:0];
                    PAT_ZEROS:  gen_byte = 8'h00;
                    PAT_ONES:   gen_byte = 8'hff;
                    PAT_ALT55:  gen_byte = 8'h55;
                    PAT_DOWN:   gen_byte = 8'hff - bcnt_q[7:0];
                    default:    gen_byte = 8'h00;
                endcase
            end
            FG_FCS: begin
                gen_byte = ~fcs_sh[7:0];
            end
            FG_IDLE, FG_GAP: begin
                gen_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phy_txd_q <= 8'h00;
            phy_en_q  <= 1'b0;
            phy_stb_q <= 1'b0;
        end else if (gen_en_q) begin
            phy_txd_q <= gen_byte;
            phy_en_q  <= run & gen_tx;
            phy_stb_q <= run & tick & ~start;
        end else begin
            phy_txd_q <= mac_txd_i;
            phy_en_q  <= mac_tx_en_i;
            phy_stb_q <= mac_tx_stb_i;
        end
    end

    assign dat_o        = dat_q;
    assign ack_o        = ack_q;
    assign phy_txd_o    = phy_txd_q;
    assign phy_tx_en_o  = phy_en_q;
    assign phy_tx_stb_o = phy_stb_q;

endmodule

// [sim/fgd_mac_src.sv]
module fgd_mac_src (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    output logic      [7:0] txd_o,
    output logic            tx_en_o,
    output logic            tx_stb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // The byte changes every cycle, so a stale path shows at once.
    logic [7:0] n_q = 8'h00;
    always @(posedge clk_i) begin
        if (rst_i) begin
            n_q <= 8'h00;
        end else begin
            n_q <= n_q + 8'h01;
        end
    end
    assign txd_o    = n_q ^ 8'h5a;
    assign tx_en_o  = n_q[5];
    assign tx_stb_o = n_q[1:0] == 2'h0;
endmodule

// [sim/fgd_frame_gen_diag_chk.sv]
module fgd_frame_gen_diag_chk
    import fgd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [17:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        rx_error_i,
    input wire logic        odd_preamble_i,
    input wire logic        bad_ssd_i,
    input wire logic [7:0]  mac_txd_i,
    input wire logic        mac_tx_en_i,
    input wire logic        mac_tx_stb_i,
    input wire logic [7:0]  phy_txd_o,
    input wire logic        phy_tx_en_o,
    input wire logic        phy_tx_stb_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        en_q, mask_q;
    logic [15:0] odd_q, fc_q, odd_snap_q, fc_snap_q;
    wire logic [15:0] idx = adr_i[17:2];
    wire logic        wr  = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    wire logic        rd  = ack_o && !we_i;
    wire logic        tk  = cyc_i && stb_i && !we_i && !ack_o;
    // Same-cycle events at the counter read are kept out by the bench.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q       <= 1'b0;
            mask_q     <= 1'b0;
            odd_q      <= 16'h0000;
            fc_q       <= 16'h0000;
            odd_snap_q <= 16'h0000;
            fc_snap_q  <= 16'h0000;
        end else begin
            if (wr && idx == IDX_GEN_EN) en_q <= dat_i[ENABLE_BIT];
            if (wr && idx == IDX_IRQ_MASK) mask_q <= dat_i[IRQ_GEN_BIT];
            odd_q <= odd_q + {15'h0000, odd_preamble_i};
            fc_q  <= fc_q + {15'h0000, bad_ssd_i};
            if (tk && idx == IDX_RX_ERR) odd_snap_q <= odd_q;
            if (tk && idx == IDX_RX_ERR) fc_snap_q <= fc_q;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack not in cycle after request");
    read_upper_a: assert property (
        rd |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    odd_snap_a: assert property (
        rd && idx == IDX_ODD_PRE |-> dat_o[15:0] == odd_snap_q)
        else $error("odd preamble copy wrong");
    false_snap_a: assert property (
        rd && idx == IDX_FALSE_CAR |-> dat_o[15:0] == fc_snap_q)
        else $error("false carrier copy wrong");
    restart_clear_a: assert property (
        rd && idx == IDX_GEN_CTRL |-> !dat_o[RESTART_BIT])
        else $error("restart bit reads back set");
    mac_pass_a: assert property (
        !en_q && !$past(en_q) && !$past(rst_i) |->
        phy_txd_o == $past(mac_txd_i) && phy_tx_en_o == $past(mac_tx_en_i)
        && phy_tx_stb_o == $past(mac_tx_stb_i))
        else $error("phy output not following mac stream");
    irq_mask_a: assert property (irq_o |-> mask_q)
        else $error("interrupt while masked");
    byte_gap_a: assert property (
        phy_tx_stb_o && en_q && $past(en_q) |=>
        (!phy_tx_stb_o || !en_q) [*8])
        else $error("generator bytes too close");
endmodule
bind fgd_frame_gen_diag fgd_frame_gen_diag_chk u_chk (.*);

// [sim/tb_top.sv]
module tb_top
    import fgd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, rx_error_i = 1'b0, odd_preamble_i = 1'b0;
    logic        bad_ssd_i = 1'b0, ack_o, phy_tx_en_o, phy_tx_stb_o, irq_o;
    logic        mac_tx_en_i, mac_tx_stb_i;
    logic [3:0]  sel_i = 4'h0;
    logic [17:0] adr_i = 18'h00000;
    logic [31:0] dat_i = 32'h00000000, dat_o;
    logic [7:0]  mac_txd_i, phy_txd_o;
    logic [15:0] rd_q;
    logic [7:0]  byte_q[$];
    int          error_cnt = 0, tests_run = 0, cyc_cnt = 0;
    localparam logic [31:0] RTAB [11] = '{
        {IDX_ODD_PRE, 16'h0000}, {IDX_FALSE_CAR, 16'h0000},
        {IDX_GEN_EN, 16'h0000}, {IDX_GEN_CTRL, 16'h0001},
        {IDX_GEN_CONT, 16'h0000}, {IDX_GEN_IRQ_EN, 16'h0000},
        {IDX_GEN_LEN, 16'h006b}, {IDX_GEN_IFG, 16'h000c},
        {IDX_NFRM_H, 16'h0000}, {IDX_NFRM_L, 16'h0100},
        {16'h8040, 16'h0000}};
    always #10 clk_i = ~clk_i;
    fgd_frame_gen_diag DUT (.*);
    fgd_mac_src u_mac (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .txd_o    (mac_txd_i),
        .tx_en_o  (mac_tx_en_i),
        .tx_stb_o (mac_tx_stb_i)
    );
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (phy_tx_stb_o === 1'b1 && phy_tx_en_o === 1'b1) begin
            byte_q.push_back(phy_txd_o);
        end
        if (cyc_cnt == 40000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [15:0] ix, d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {ix, 2'h0};
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd_q = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic ev(input logic [2:0] m);
        @(posedge clk_i);
        {rx_error_i, odd_preamble_i, bad_ssd_i} <= m;
        @(posedge clk_i);
        {rx_error_i, odd_preamble_i, bad_ssd_i} <= 3'h0;
    endtask
    // MAC stream bytes may still land in the edge after a start.
    task automatic run(input logic [2:0] p, input logic [15:0] nf);
        wb(1'b1, IDX_GEN_EN, 16'h0000);
        wb(1'b1, IDX_NFRM_L, nf);
        wb(1'b1, IDX_GEN_CTRL, {13'h0000, p});
        wb(1'b1, IDX_GEN_EN, 16'h0001);
        repeat (2) @(negedge clk_i);
        byte_q.delete();
    endtask
    function automatic logic [15:0] exp_b(input int p, input int k);
        if (k < 6) return {8'h00, DST_BYTE};
        if (k < 12) return {8'h00, SRC_MAC[8 * (11 - k) +: 8]};
        if (k < 14) return (k == 12) ? 16'h0000 : 16'h0002;
        case (3'(p))
            PAT_ONES: return 16'h00ff;
            PAT_ALT55: return 16'h0055;
            PAT_DOWN: return 16'h00ff - 16'(k - 14);
            default: return 16'h0000;
        endcase
    endfunction
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 16'h8040, 16'hbeef);
        foreach (RTAB[i]) begin
            wb(1'b0, RTAB[i][31:16], 16'h0000);
            chk("reset value", rd_q, RTAB[i][15:0]);
        end
        wb(1'b1, IDX_GEN_LEN, 16'h0002);
        wb(1'b0, IDX_GEN_LEN, 16'h0000);
        chk("length", rd_q, 16'h0002);
        repeat (2) ev(3'h7);
        ev(3'h2);
        repeat (3) ev(3'h1);
        wb(1'b0, IDX_ODD_PRE, 16'h0000);
        chk("odd early", rd_q, 16'h0000);
        wb(1'b0, IDX_RX_ERR, 16'h0000);
        chk("rx err", rd_q, 16'h0002);
        wb(1'b0, IDX_RX_ERR, 16'h0000);
        chk("rx err clr", rd_q, 16'h0000);
        wb(1'b0, IDX_ODD_PRE, 16'h0000);
        chk("odd", rd_q, 16'h0003);
        wb(1'b0, IDX_FALSE_CAR, 16'h0000);
        chk("false", rd_q, 16'h0005);
        wb(1'b1, IDX_DIAG_CLK, 16'h0001);
        wb(1'b1, IDX_GEN_IRQ_EN, 16'h0001);
        for (int p = 1; p < 6; p++) begin
            run(3'(p), (p == 2) ? 16'h0002 : 16'h0001);
            do wb(1'b0, IDX_GEN_DONE, 16'h0000); while (rd_q[0] !== 1'b1);
            chk("bytes", 16'(byte_q.size()),
                (p == 2) ? 16'h0028 : 16'h0014);
            for (int k = 0; k < ((p == 1) ? 14 : 16); k++) begin
                chk("byte", {8'h00, byte_q[k]}, exp_b(p, k));
            end
            wb(1'b0, IDX_GEN_DONE, 16'h0000);
            chk("done clr", rd_q, 16'h0000);
            @(negedge clk_i);
            chk("irq masked", {15'h0000, irq_o}, 16'h0000);
            wb(1'b1, IDX_IRQ_MASK, 16'h0001);
            @(negedge clk_i);
            chk("irq", {15'h0000, irq_o}, 16'h0001);
            wb(1'b1, IDX_IRQ_STAT, 16'h0001);
            @(negedge clk_i);
            chk("irq clr", {15'h0000, irq_o}, 16'h0000);
            wb(1'b1, IDX_IRQ_MASK, 16'h0000);
        end
        wb(1'b1, IDX_GEN_CONT, 16'h0001);
        run(PAT_ONES, 16'h0001);
        while (byte_q.size() < 60) @(posedge clk_i);
        wb(1'b0, IDX_GEN_DONE, 16'h0000);
        chk("cont done", rd_q, 16'h0000);
        wb(1'b1, IDX_GEN_CTRL, 16'h000b);
        repeat (2) @(negedge clk_i);
        byte_q.delete();
        while (byte_q.size() < 14) @(posedge clk_i);
        for (int k = 0; k < 14; k++) begin
            chk("restart", {8'h00, byte_q[k]}, exp_b(3, k));
        end
        wb(1'b0, IDX_GEN_CTRL, 16'h0000);
        chk("restart bit", rd_q, 16'h0003);
        run(PAT_STOP, 16'h0001);
        repeat (100) @(posedge clk_i);
        chk("stopped", 16'(byte_q.size()), 16'h0000);
        wb(1'b1, IDX_GEN_EN, 16'h0000);
        tally_and_finish();
    end
endmodule
